// [src/cgu_defs.svh]
// Purpose: Constants for the clock generation unit with oscillator halt detection.
// Assumes: sys_clk is a free-running on-chip clock at 100 MHz.
// Notes:   Times are kept in their own unit, cycle counts are derived from them.
`ifndef CGU_DEFS_SVH
`define CGU_DEFS_SVH

// =====================================================================
// Timing
`define CGU_SYS_CLK_MHZ      100
`define CGU_HALT_TIMEOUT_NS  2000
`define CGU_HALT_TIMEOUT_CYC ((`CGU_HALT_TIMEOUT_NS * `CGU_SYS_CLK_MHZ) / 1000)
`define CGU_HALT_CNT_W       8

// =====================================================================
// Structure
`define CGU_SYS_DIV_STAGES   13
`define CGU_PER_DIV_STAGES   10
`define CGU_HC_PINS          6
`define CGU_PERIOD_W         8
`define CGU_PERIOD_MAX       8'hFF
`define CGU_PCLK_RATIO       2'h2
`define CGU_HIZ_EN_RST       1'b0

`endif

// [src/cgu_pkg.sv]
// Purpose: Types for the clock generation unit.
// Assumes: Constants live in cgu_defs.svh.
// Notes:   Clock enables travel as packed structs, one per clock group.
package cgu_pkg;

  // =====================================================================
  // Clock mode pin encodings, giving the multiplication shift.
  typedef enum logic [1:0] {
    CGU_MULT_X1   = 2'h0,
    CGU_MULT_X2   = 2'h1,
    CGU_MULT_X4   = 2'h2,
    CGU_MULT_RSVD = 2'h3
  } cgu_mult_t;

  // Supervisor states, Gray coded along run, standby, halted.
  typedef enum logic [1:0] {
    CGU_RUN    = 2'h0,
    CGU_STBY   = 2'h1,
    CGU_HALTED = 2'h3
  } cgu_state_t;

  // System clock group enables.
  typedef struct packed {
    logic core;
    logic brk;
    logic xfer;
    logic bus;
    logic dma;
    logic wdog;
    logic dbg;
    logic rom;
    logic ram;
  } cgu_sys_en_t;

  // Peripheral clock group enables.
  typedef struct packed {
    logic timer;
    logic out_disable;
    logic serial;
    logic i2c;
    logic converter;
    logic cmp_timer;
    logic scan;
  } cgu_per_en_t;

  // High-current pin drive, output value and output enable.
  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe;
  } cgu_hc_pins_t;

endpackage : cgu_pkg

// [src/cgu_clock_unit.sv]
// Purpose: Clock generation unit: PLL model, prescalers, group enables and halt watch.
// Assumes: sys_clk is free running and independent of the oscillator input.
// Notes:   Clocks leave the block as one-cycle enable pulses on sys_clk.
//
// How it works
// - A system tick and a peripheral tick are made and prescaled into /2 to /8192 and /2 to /1024 pulses.
// - Core-side modules get the system tick and peripheral modules get the peripheral tick.
// - The oscillator edges pass a PLL stage that sets the system tick rate from the measured input period.
// - The clock mode pins choose one, two or four system ticks per oscillator period.
// - With no oscillator edge seen and hiz_en set, the six high-current pins are forced to high impedance.
// - In software standby the six high-current pins can be forced to high impedance.
// - After standby ends the six pins follow the pin function controller again.
// - A halt outside standby is held until reset, even if the oscillator restarts.
`include "cgu_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module cgu_clock_unit
  import cgu_pkg::*;
(
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  input  wire logic                             osc_input_pin,
  input  wire logic [1:0]                       clk_mode_pin,
  input  wire logic                             stby_req,
  input  wire logic                             hiz_en_wr,
  input  wire logic                             hiz_en_wdata,
  input  wire cgu_hc_pins_t                     pfc_pins,
  output cgu_hc_pins_t                          hc_pins,
  output logic                                  hiz_en,
  output logic                                  osc_halted,
  output logic                                  sys_tick,
  output logic                                  per_tick,
  output logic [`CGU_SYS_DIV_STAGES-1:0]        sys_div_tick,
  output logic [`CGU_PER_DIV_STAGES-1:0]        per_div_tick,
  output cgu_sys_en_t                           sys_en,
  output cgu_per_en_t                           per_en
);

  // =====================================================================
  // Input synchronisers
  logic                        osc_s1_q;
  logic                        osc_s2_q;
  logic                        osc_s3_q;
  logic [1:0]                  mode_s1_q;
  logic [1:0]                  mode_s2_q;
  logic                        osc_rise;
  logic                        osc_edge;

  // Two flops per pin; the third oscillator flop only serves edge detection.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
    end else begin
      osc_s1_q  <= osc_input_pin;
      osc_s2_q  <= osc_s1_q;
      osc_s3_q  <= osc_s2_q;
      mode_s1_q <= clk_mode_pin;
      mode_s2_q <= mode_s1_q;
    end
  end

  assign osc_rise = osc_s2_q & ~osc_s3_q;
  assign osc_edge = osc_s2_q ^ osc_s3_q;

  // =====================================================================
  // Halt supervisor
  cgu_state_t                  state_q;
  logic [`CGU_HALT_CNT_W-1:0]  halt_cnt_q;
  logic                        hiz_en_q;
  logic                        force_hiz;

  // Edge watchdog; cleared in standby because the source is legally stopped there.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || osc_edge || state_q != CGU_RUN) begin
      halt_cnt_q <= '0;
    end else if (halt_cnt_q != `CGU_HALT_CNT_W'(`CGU_HALT_TIMEOUT_CYC - 1)) begin
      halt_cnt_q <= halt_cnt_q + 1'b1;
    end
  end

  // Run, standby and a halted state that only reset leaves.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= CGU_RUN;
    end else begin
      unique case (state_q)
        CGU_RUN: begin
          if (stby_req) begin
            state_q <= CGU_STBY;
          end else if (!osc_edge && halt_cnt_q == `CGU_HALT_CNT_W'(`CGU_HALT_TIMEOUT_CYC - 1)) begin
            state_q <= CGU_HALTED;
          end
        end
        CGU_STBY: begin
          if (!stby_req) begin
            state_q <= CGU_RUN;
          end
        end
        CGU_HALTED: begin
          state_q <= CGU_HALTED;
        end
        default: begin
          state_q <= CGU_HALTED;
        end
      endcase
    end
  end

  // Software enable for the high-impedance override.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hiz_en_q <= `CGU_HIZ_EN_RST;
    end else if (hiz_en_wr) begin
      hiz_en_q <= hiz_en_wdata;
    end
  end

  assign force_hiz = hiz_en_q && (state_q != CGU_RUN);

  // Pin drive is registered; the override beats the pin function selection.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hc_pins <= '0;
    end else begin
      hc_pins.o  <= pfc_pins.o;
      hc_pins.oe <= force_hiz ? 6'h00 : pfc_pins.oe;
    end
  end

  assign hiz_en     = hiz_en_q;
  assign osc_halted = (state_q == CGU_HALTED);

  // =====================================================================
  // PLL stage
  logic [`CGU_PERIOD_W-1:0]    per_cnt_q;
  logic [`CGU_PERIOD_W-1:0]    period_q;
  logic [`CGU_PERIOD_W-1:0]    phase_q;
  logic [`CGU_PERIOD_W-1:0]    slice;
  logic [1:0]                  shift;
  logic                        sys_tick_q;

  // Reserved mode code falls back to times one.
  assign shift = (mode_s2_q == CGU_MULT_RSVD) ? 2'h0 : mode_s2_q;
  assign slice = ((period_q >> shift) == '0) ? `CGU_PERIOD_W'(1) : (period_q >> shift);

  // Measures the oscillator period in sys_clk cycles.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      per_cnt_q <= '0;
      period_q  <= '0;
    end else if (osc_rise) begin
      period_q  <= per_cnt_q + 1'b1;
      per_cnt_q <= '0;
    end else if (per_cnt_q != `CGU_PERIOD_MAX) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // Splits each period into one, two or four ticks, realigned on each rising edge.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_q != CGU_RUN || period_q == '0) begin
      phase_q    <= '0;
      sys_tick_q <= 1'b0;
    end else if (osc_rise || phase_q == slice - 1'b1) begin
      phase_q    <= '0;
      sys_tick_q <= 1'b1;
    end else begin
      phase_q    <= phase_q + 1'b1;
      sys_tick_q <= 1'b0;
    end
  end

  // =====================================================================
  // Peripheral tick and prescalers
  logic [1:0]                     pratio_q;
  logic                           per_tick_q;
  logic [`CGU_SYS_DIV_STAGES-1:0] sys_pre_q;
  logic [`CGU_PER_DIV_STAGES-1:0] per_pre_q;

  // Peripheral tick is the system tick divided by a fixed ratio.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pratio_q   <= '0;
      per_tick_q <= 1'b0;
    end else if (sys_tick_q) begin
      pratio_q   <= (pratio_q == `CGU_PCLK_RATIO - 2'h1) ? 2'h0 : pratio_q + 2'h1;
      per_tick_q <= (pratio_q == `CGU_PCLK_RATIO - 2'h1);
    end else begin
      per_tick_q <= 1'b0;
    end
  end

  // Prescaler counters advance on their own base tick.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sys_pre_q <= '0;
      per_pre_q <= '0;
    end else begin
      if (sys_tick_q) begin
        sys_pre_q <= sys_pre_q + 1'b1;
      end
      if (per_tick_q) begin
        per_pre_q <= per_pre_q + 1'b1;
      end
    end
  end

  // Stage k pulses once every 2^(k+1) base ticks.
  for (genvar k = 0; k < `CGU_SYS_DIV_STAGES; k++) begin : g_sys_div
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        sys_div_tick[k] <= 1'b0;
      end else begin
        sys_div_tick[k] <= sys_tick_q & (&sys_pre_q[k:0]);
      end
    end
    if (k < `CGU_PER_DIV_STAGES) begin : g_per_div
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          per_div_tick[k] <= 1'b0;
        end else begin
          per_div_tick[k] <= per_tick_q & (&per_pre_q[k:0]);
        end
      end
    end
  end

  // Group enables fan the two base ticks out to their modules.
  assign sys_tick = sys_tick_q;
  assign per_tick = per_tick_q;
  assign sys_en   = {9{sys_tick_q}};
  assign per_en   = {7{per_tick_q}};

  // =====================================================================
  // Checks
  chk_hiz_on_halt: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_q == CGU_HALTED && hiz_en_q) |=> (hc_pins.oe == 6'h00))
    else $error("High-current pins driven after oscillator halt.");

  chk_hiz_in_stby: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (stby_req && hiz_en_q && state_q == CGU_RUN) |=> ##1 (hc_pins.oe == 6'h00))
    else $error("High-current pins driven in standby.");

  chk_pins_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_q == CGU_RUN && !sys_rst) |=> (hc_pins.oe == $past(pfc_pins.oe)))
    else $error("High-current pins do not follow the function controller.");

  chk_halt_timeout: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_q == CGU_RUN && !stby_req && !osc_edge
     && halt_cnt_q == `CGU_HALT_CNT_W'(`CGU_HALT_TIMEOUT_CYC - 1)) |=> osc_halted)
    else $error("Halt not flagged at the timeout.");

  chk_halt_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
    osc_halted |=> osc_halted [*3])
    else $error("Halted state left without reset.");

  chk_en_reset: assert property (@(posedge sys_clk)
    ($past(sys_rst) && !sys_rst) |-> !hiz_en_q)
    else $error("Override enable not cleared by reset.");

  chk_no_tick_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_q != CGU_RUN) |=> !sys_tick_q)
    else $error("System tick while oscillator stopped or halted.");

  chk_div_nest: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sys_div_tick[12] |-> sys_div_tick[0]) and (per_div_tick[9] |-> per_div_tick[0]))
    else $error("Prescaler stages not nested.");

  chk_grp_en: assert property (@(posedge sys_clk) disable iff (sys_rst)
    per_tick_q |-> (per_en.timer && per_en.scan && $past(sys_tick_q)))
    else $error("Group enables out of step with base ticks.");

endmodule : cgu_clock_unit

`default_nettype wire

// [sim/cgu_osc_model.sv]
// Purpose: Outside clock source model for the clock generation unit.
// Assumes: It runs free of sys_clk and parks high when told to stop.
// Notes:   The period is a parameter; 80 ns is 12.5 MHz, the top of the range.
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Source model
module cgu_osc_model #(
  parameter int PERIOD_NS = 80
) (
  input  wire logic stop_in,
  output var  logic osc_out
);
  // Toggle each half period, park high while stopped, start off phase.
  initial begin
    osc_out = 1'b0;
    #3;
    forever begin
      #(PERIOD_NS / 2);
      if (stop_in)
        osc_out = 1'b1;
      else
        osc_out = ~osc_out;
    end
  end
endmodule : cgu_osc_model
`default_nettype wire

// [sim/test_clock_generator_halt_detect.sv]
// Purpose: Self-checking bench for the clock generation unit.
// Assumes: Pin drive expectations follow the two-cycle standby walk.
// Notes:   Rate tick counts allow one tick of slack for phase; the halt tick count allows none.
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Bench
module test_clock_generator_halt_detect
  import cgu_pkg::*;
();
  typedef struct {int due; cgu_hc_pins_t hc; logic hz;} cgu_exp_t;
  logic         sys_clk, sys_rst, stby_req, hiz_en_wr, hiz_en_wdata, halt_cmd;
  logic [1:0]   clk_mode_pin;
  wire logic    osc;
  cgu_hc_pins_t pfc_pins, hc_pins;
  logic         hiz_en, osc_halted, sys_tick, per_tick;
  logic [12:0]  sys_div_tick;
  logic [9:0]   per_div_tick;
  cgu_sys_en_t  sys_en;
  cgu_per_en_t  per_en;
  int           cyc = 0;
  int           lr, miscompares, num_checks, n_sys, n_per, n_sd, n_pd;
  bit           trk, hz_m, st_p, hlt_m;
  cgu_exp_t     q[$];
  cgu_exp_t     e;

  // Clock and cycle count.
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  always @(posedge osc) lr = cyc;

  cgu_osc_model #(.PERIOD_NS(80)) osc_u (.stop_in(stby_req | halt_cmd), .osc_out(osc));

  cgu_clock_unit dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .osc_input_pin(osc),
    .clk_mode_pin(clk_mode_pin), .stby_req(stby_req), .hiz_en_wr(hiz_en_wr),
    .hiz_en_wdata(hiz_en_wdata), .pfc_pins(pfc_pins), .hc_pins(hc_pins), .hiz_en(hiz_en),
    .osc_halted(osc_halted), .sys_tick(sys_tick), .per_tick(per_tick),
    .sys_div_tick(sys_div_tick), .per_div_tick(per_div_tick), .sys_en(sys_en), .per_en(per_en));

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
    num_checks++;
    if (g !== ex) begin
      miscompares++;
      $display("MISMATCH %s exp %0h got %0h", nm, ex, g);
    end
  endtask : chk

  task automatic near(input string nm, input int ex, input int g, input int tol);
    num_checks++;
    if (g > ex + tol || g < ex - tol) begin
      miscompares++;
      $display("MISMATCH %s exp %0d got %0d", nm, ex, g);
    end
  endtask : near

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // One cycle of drive; the pin drive it causes shows after the second edge.
  task automatic step(input logic st, input logic wr, input logic wd);
    cgu_hc_pins_t v;
    logic         frc;
    v = 12'($urandom);
    frc = hz_m & (st_p | hlt_m);
    st_p = st;
    if (wr)
      hz_m = wd;
    pfc_pins <= v;
    stby_req <= st;
    hiz_en_wr <= wr;
    hiz_en_wdata <= wd;
    if (trk)
      q.push_back('{cyc + 2, '{v.o, (frc ? 6'h00 : v.oe)}, hz_m});
    @(posedge sys_clk);
  endtask : step

  // Reset with a clock mode, then allow the stabilization wait.
  task automatic do_reset(input logic [1:0] m);
    sys_rst <= 1'b1;
    clk_mode_pin <= m;
    halt_cmd <= 1'b0;
    stby_req <= 1'b0;
    hiz_en_wr <= 1'b0;
    {trk, hz_m, st_p, hlt_m} = 4'h0;
    q.delete();
    repeat (11) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("reset_out", 16'h0000, 16'({hc_pins, hiz_en, osc_halted, sys_tick}));
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (40) step(1'b0, 1'b0, 1'b0);
    trk = 1'b1;
  endtask : do_reset

  // Count ticks over 80 cycles, ten input periods.
  task automatic ticks(input int mult);
    {n_sys, n_per, n_sd, n_pd} = '0;
    repeat (80) step(1'b0, 1'b0, 1'b0);
    near("sys_tick", 10 * mult, n_sys, 1);
    near("per_tick", 5 * mult, n_per, 1);
    near("sys_div0", 5 * mult, n_sd, 1);
    near("per_div0", 5 * mult / 2, n_pd, 1);
  endtask : ticks

  // Output watcher: group enables every cycle, queued pin notes when due.
  always @(negedge sys_clk) begin
    if (sys_rst === 1'b0) begin
      n_sys += int'(sys_tick);
      n_per += int'(per_tick);
      n_sd += int'(sys_div_tick[0]);
      n_pd += int'(per_div_tick[0]);
      chk("sys_en", 16'({9{sys_tick}}), 16'(sys_en));
      chk("per_en", 16'({7{per_tick}}), 16'(per_en));
      if (q.size() > 0 && q[0].due == cyc) begin
        e = q.pop_front();
        chk("hc_pins", 16'(e.hc), 16'(hc_pins));
        chk("hiz_en", 16'(e.hz), 16'(hiz_en));
      end
    end
  end

  // Main sequence.
  initial begin
    {sys_rst, stby_req, hiz_en_wr, hiz_en_wdata, halt_cmd} = 5'h10;
    pfc_pins = '0;
    clk_mode_pin = 2'h0;
    void'($urandom(32'hA71E54AA));
    for (int m = 0; m < 4; m++) begin
      do_reset(2'(m));
      ticks(m == 1 ? 2 : (m == 2 ? 4 : 1));
    end
    repeat (6) step(1'b1, 1'b0, 1'b0);
    repeat (20) step(1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b1);
    repeat (6) step(1'b1, 1'b0, 1'b0);
    repeat (20) step(1'b0, 1'b0, 1'b0);
    // Stop the source outside standby and time the halt flag.
    trk = 1'b0;
    halt_cmd <= 1'b1;
    for (int i = 0; i < 400 && osc_halted !== 1'b1; i++) begin
      step(1'b0, 1'b0, 1'b0);
    end
    // A halt flag that never comes counts as a mismatch and skips to the report.
    if (osc_halted !== 1'b1) begin
      miscompares++;
    end else begin
      near("halt_delay", 205, cyc - lr, 5);
      hlt_m = 1'b1;
      repeat (2) step(1'b0, 1'b0, 1'b0);
      trk = 1'b1;
      n_sys = 0;
      repeat (10) step(1'b0, 1'b0, 1'b0);
      halt_cmd <= 1'b0;
      repeat (40) step(1'b0, 1'b0, 1'b0);
      chk("osc_halted", 16'h0001, 16'(osc_halted));
      near("halt_ticks", 0, n_sys, 0);
      do_reset(2'h0);
      chk("osc_halted", 16'h0000, 16'(osc_halted));
    end
    end_sim();
  end
endmodule : test_clock_generator_halt_detect
`default_nettype wire
